//--- src/isb_scoreboard.sv
`timescale 1ns/1ps
`include "isb_cfg.svh"

module isb_scoreboard (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ent_valid,
    input wire logic [1:0] ent_kind,
    input wire logic [`ISB_SB_W-1:0] ent_mask,
    input wire logic [`ISB_IDX_W-1:0] ent_idx,
    input wire logic [`ISB_AGE_W-1:0] ent_age,
    output logic ent_accept_q,
    output logic [`ISB_SLOT_W-1:0] ent_slot_q,
    input wire logic iss_valid,
    input wire logic [`ISB_SLOT_W-1:0] iss_slot,
    input wire logic [`ISB_DW-1:0] iss_wdata,
    output logic [`ISB_NSLOT-1:0] iss_ok_q,
    output logic rd_valid_q,
    output logic [`ISB_DW-1:0] rd_data_q,
    input wire logic ret_valid,
    input wire logic [`ISB_SLOT_W-1:0] ret_slot,
    output logic [`ISB_NSLOT-1:0] ret_ok_q,
    input wire logic kill_valid,
    input wire logic [`ISB_AGE_W-1:0] kill_age,
    input wire logic pte_load_issue,
    output logic tb_barrier_q,
    output logic [`ISB_SB_W-1:0] sb_bits_q,
    output logic [`ISB_DW-1:0] data_tb_tag_reg_q,
    output logic [`ISB_DW-1:0] data_tb_entry_reg_q,
    input wire logic exc_valid,
    input wire logic [`ISB_AGE_W-1:0] exc_age,
    input wire logic [`ISB_DW-1:0] exc_pc,
    input wire logic [`ISB_DW-1:0] exc_va,
    input wire logic [`ISB_STAT_W-1:0] exc_stat,
    output logic [`ISB_DW-1:0] exception_pc_reg_q,
    output logic [`ISB_DW-1:0] fault_virtual_address_reg_q,
    output logic [`ISB_STAT_W-1:0] memory_fault_status_reg_q,
    output logic exc_locked_q
);
    isb_pkg::isb_kind_t ent_k;
    logic [`ISB_NSLOT-1:0] s_valid, s_issued, s_alloc, s_iss, s_free;
    logic [`ISB_NSLOT-1:0] s_killed, iss_ok_d, ret_ok_d;
    isb_pkg::isb_kind_t s_kind [`ISB_NSLOT];
    logic [`ISB_SB_W-1:0] s_mask [`ISB_NSLOT];
    logic [`ISB_AGE_W-1:0] s_age [`ISB_NSLOT];
    logic [`ISB_IDX_W-1:0] s_idx [`ISB_NSLOT];

    logic [`ISB_SB_W-1:0] sb_d, alloc_mask;
    logic ent_ok, ent_d, free_found, dep_block, iss_go, ret_go;
    logic [`ISB_SLOT_W-1:0] free_slot, slot_d;
    logic [`ISB_STG_W-1:0] iss_grp, ret_grp;

    logic [`ISB_DW-1:0] stg_q [`ISB_NSTG];
    logic [`ISB_DW-1:0] stg_d [`ISB_NSTG];
    logic [`ISB_IDX_W-1:0] stg_dst_q [`ISB_NSTG];
    logic [`ISB_IDX_W-1:0] stg_dst_d [`ISB_NSTG];
    logic [`ISB_DW-1:0] com_q [`ISB_NREG];
    logic [`ISB_DW-1:0] com_d [`ISB_NREG];
    logic rd_valid_d, tb_barrier_d;
    logic [`ISB_DW-1:0] rd_data_d;
    logic [`ISB_DW-1:0] pc_w, va_w;
    logic [`ISB_STAT_W-1:0] stat_w;
    logic lk_pc, lk_va, lk_stat, locked_d;

    assign ent_k = isb_pkg::isb_kind_t'(ent_kind);

    genvar g;
    generate
        for (g = 0; g < `ISB_NSLOT; g++) begin : g_slot
            isb_slot u_slot (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .alloc(s_alloc[g]),
                .alloc_kind(ent_k),
                .alloc_mask(alloc_mask),
                .alloc_age(ent_age),
                .alloc_idx(ent_idx),
                .mark_issued(s_iss[g]),
                .free(s_free[g]),
                .valid(s_valid[g]),
                .kind(s_kind[g]),
                .mask(s_mask[g]),
                .age(s_age[g]),
                .idx(s_idx[g]),
                .issued(s_issued[g])
            );
        end
    endgenerate

    // Entry side: free slot, readers still waiting, and stall decision
    always_comb begin
        free_found = 1'b0;
        free_slot = '0;
        dep_block = 1'b0;
        for (int i = `ISB_NSLOT - 1; i >= 0; i--) begin
            if (!s_valid[i]) begin
                free_found = 1'b1;
                free_slot = `ISB_SLOT_W'(i);
            end
            if (s_valid[i] && !s_issued[i] &&
                (s_kind[i] == isb_pkg::k_read ||
                 s_kind[i] == isb_pkg::k_mem) &&
                ((s_mask[i] & ent_mask) != '0)) begin
                dep_block = 1'b1;
            end
        end
        case (ent_k)
            isb_pkg::k_read, isb_pkg::k_write: begin
                alloc_mask = ent_mask;
            end
            isb_pkg::k_mem: begin
                // Capture only the low bits set at entry
                alloc_mask = {4'h0, sb_bits_q[`ISB_LO_MSB:0]};
            end
            default: begin
                alloc_mask = '0;
            end
        endcase
        // One entry per two cycles so a request held one cycle past its accept is not taken twice
        ent_ok = ent_valid && !ent_accept_q && free_found &&
            !(kill_valid && !isb_pkg::isb_older(ent_age, kill_age));
        if ((ent_k == isb_pkg::k_read || ent_k == isb_pkg::k_write) &&
            (((sb_bits_q & ent_mask) != '0) || dep_block)) begin
            ent_ok = 1'b0;
        end
        s_alloc = '0;
        if (ent_ok) begin
            s_alloc[free_slot] = 1'b1;
        end
        ent_d = ent_ok;
        slot_d = ent_ok ? free_slot : ent_slot_q;
    end

    // Issue and retire eligibility per slot
    always_comb begin
        for (int i = 0; i < `ISB_NSLOT; i++) begin
            case (s_kind[i])
                isb_pkg::k_read: begin
                    // No check against other reads
                    iss_ok_d[i] = (sb_bits_q & s_mask[i]) == '0;
                end
                isb_pkg::k_mem: begin
                    iss_ok_d[i] = (sb_bits_q[`ISB_LO_MSB:0] &
                        s_mask[i][`ISB_LO_MSB:0]) == 4'h0;
                end
                default: begin
                    iss_ok_d[i] = 1'b1;
                end
            endcase
            iss_ok_d[i] = iss_ok_d[i] && s_valid[i] && !s_issued[i];
            ret_ok_d[i] = s_valid[i] && s_issued[i];
            for (int j = 0; j < `ISB_NSLOT; j++) begin
                if (s_kind[i] == isb_pkg::k_write && s_valid[j] &&
                    s_kind[j] == isb_pkg::k_read && s_idx[j] == s_idx[i] &&
                    isb_pkg::isb_older(s_age[j], s_age[i])) begin
                    ret_ok_d[i] = 1'b0;
                end
            end
            s_killed[i] = kill_valid && s_valid[i] &&
                !isb_pkg::isb_older(s_age[i], kill_age);
        end
        iss_go = iss_valid && iss_ok_d[iss_slot];
        ret_go = ret_valid && ret_ok_d[ret_slot];
        s_iss = '0;
        s_free = s_killed;
        if (iss_go) begin
            s_iss[iss_slot] = 1'b1;
        end
        if (ret_go) begin
            s_free[ret_slot] = 1'b1;
        end
    end

    // Scoreboard bits: clears first, then the entry set so a set wins
    always_comb begin
        sb_d = sb_bits_q;
        if (iss_go && s_kind[iss_slot] == isb_pkg::k_write) begin
            sb_d[`ISB_LO_MSB:0] = sb_d[`ISB_LO_MSB:0] &
                ~s_mask[iss_slot][`ISB_LO_MSB:0];
        end
        if (ret_go && s_kind[ret_slot] == isb_pkg::k_write) begin
            sb_d[`ISB_UP_MSB:`ISB_UP_LSB] = sb_d[`ISB_UP_MSB:`ISB_UP_LSB] &
                ~s_mask[ret_slot][`ISB_UP_MSB:`ISB_UP_LSB];
        end
        for (int i = 0; i < `ISB_NSLOT; i++) begin
            if (s_killed[i] && s_kind[i] == isb_pkg::k_write) begin
                sb_d = sb_d & ~s_mask[i];
            end
        end
        if (ent_ok && ent_k == isb_pkg::k_write) begin
            sb_d = sb_d | ent_mask;
        end
    end

    // Staging and committed copies of the explicitly written registers
    assign iss_grp = s_idx[iss_slot][`ISB_IDX_W-1:1];
    assign ret_grp = s_idx[ret_slot][`ISB_IDX_W-1:1];

    always_comb begin
        stg_d = stg_q;
        stg_dst_d = stg_dst_q;
        com_d = com_q;
        rd_valid_d = 1'b0;
        rd_data_d = rd_data_q;
        if (iss_go && s_kind[iss_slot] == isb_pkg::k_write) begin
            // Neighbouring indices share one staging register
            stg_d[iss_grp] = iss_wdata;
            stg_dst_d[iss_grp] = s_idx[iss_slot];
        end
        if (iss_go && s_kind[iss_slot] == isb_pkg::k_read) begin
            rd_valid_d = 1'b1;
            rd_data_d = com_q[s_idx[iss_slot]];
        end
        if (ret_go && s_kind[ret_slot] == isb_pkg::k_write) begin
            com_d[stg_dst_q[ret_grp]] = stg_q[ret_grp];
        end
        // Barrier only while a fill flow still owns bit zero
        tb_barrier_d = pte_load_issue && sb_bits_q[`ISB_FILL_BIT];
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sb_bits_q <= `ISB_SB_RST;
            ent_accept_q <= 1'b0;
            ent_slot_q <= '0;
            iss_ok_q <= '0;
            ret_ok_q <= '0;
            rd_valid_q <= 1'b0;
            rd_data_q <= `ISB_DATA_RST;
            tb_barrier_q <= 1'b0;
            exc_locked_q <= 1'b0;
            for (int i = 0; i < `ISB_NSTG; i++) begin
                stg_q[i] <= `ISB_DATA_RST;
                stg_dst_q[i] <= '0;
            end
            for (int i = 0; i < `ISB_NREG; i++) begin
                com_q[i] <= `ISB_DATA_RST;
            end
        end else begin
            sb_bits_q <= sb_d;
            ent_accept_q <= ent_d;
            ent_slot_q <= slot_d;
            iss_ok_q <= iss_ok_d & ~s_iss & ~s_free;
            ret_ok_q <= ret_ok_d & ~s_free;
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            tb_barrier_q <= tb_barrier_d;
            exc_locked_q <= locked_d;
            stg_q <= stg_d;
            stg_dst_q <= stg_dst_d;
            com_q <= com_d;
        end
    end

    assign data_tb_tag_reg_q = com_q[`ISB_REG_TAG];
    assign data_tb_entry_reg_q = com_q[`ISB_REG_ENTRY];

    // Implicitly written registers: one locked capture of the oldest live exception
    isb_excreg #(.W(`ISB_DW)) u_exc_pc (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .exc_valid(exc_valid),
        .exc_age(exc_age),
        .exc_data(exc_pc),
        .kill_valid(kill_valid),
        .kill_age(kill_age),
        .data(pc_w),
        .locked(lk_pc)
    );

    isb_excreg #(.W(`ISB_DW)) u_exc_va (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .exc_valid(exc_valid),
        .exc_age(exc_age),
        .exc_data(exc_va),
        .kill_valid(kill_valid),
        .kill_age(kill_age),
        .data(va_w),
        .locked(lk_va)
    );

    isb_excreg #(.W(`ISB_STAT_W)) u_exc_stat (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .exc_valid(exc_valid),
        .exc_age(exc_age),
        .exc_data(exc_stat),
        .kill_valid(kill_valid),
        .kill_age(kill_age),
        .data(stat_w),
        .locked(lk_stat)
    );

    assign exception_pc_reg_q = pc_w;
    assign fault_virtual_address_reg_q = va_w;
    assign memory_fault_status_reg_q = stat_w;
    assign locked_d = lk_pc | lk_va | lk_stat;
endmodule

//--- inc/isb_cfg.svh
`ifndef ISB_CFG_SVH
`define ISB_CFG_SVH

// Scoreboard geometry
`define ISB_SB_W 8
`define ISB_LO_MSB 3
`define ISB_UP_LSB 4
`define ISB_UP_MSB 7
`define ISB_FILL_BIT 0
`define ISB_SB_RST 8'h00

// Tracked slots of the issue queue and instruction age tags
`define ISB_NSLOT 8
`define ISB_SLOT_W 3
`define ISB_AGE_W 8

// Explicitly written registers and their staging groups
`define ISB_DW 64
`define ISB_NREG 8
`define ISB_IDX_W 3
`define ISB_NSTG 4
`define ISB_STG_W 2
`define ISB_REG_TAG 3'h0
`define ISB_REG_ENTRY 3'h1
`define ISB_DATA_RST 64'h0000000000000000

// Exception-written register widths
`define ISB_STAT_W 16

`endif

//--- inc/isb_pkg.sv
`include "isb_cfg.svh"

package isb_pkg;

    typedef enum logic [1:0] {
        k_read = 2'h0,
        k_write = 2'h1,
        k_mem = 2'h2,
        k_other = 2'h3
    } isb_kind_t;

    typedef enum logic {
        lk_default,
        lk_locked
    } isb_lock_t;

    // Modular age compare: tags wrap, window must stay under half the range
    function automatic logic isb_older(
        input logic [`ISB_AGE_W-1:0] a,
        input logic [`ISB_AGE_W-1:0] b
    );
        logic [`ISB_AGE_W-1:0] diff;
        diff = a - b;
        return diff[`ISB_AGE_W-1];
    endfunction

endpackage

//--- src/isb_slot.sv
`timescale 1ns/1ps
`include "isb_cfg.svh"

module isb_slot (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic alloc,
    input wire isb_pkg::isb_kind_t alloc_kind,
    input wire logic [`ISB_SB_W-1:0] alloc_mask,
    input wire logic [`ISB_AGE_W-1:0] alloc_age,
    input wire logic [`ISB_IDX_W-1:0] alloc_idx,
    input wire logic mark_issued,
    input wire logic free,
    output logic valid,
    output isb_pkg::isb_kind_t kind,
    output logic [`ISB_SB_W-1:0] mask,
    output logic [`ISB_AGE_W-1:0] age,
    output logic [`ISB_IDX_W-1:0] idx,
    output logic issued
);
    logic valid_q, valid_d, issued_q, issued_d;
    isb_pkg::isb_kind_t kind_q, kind_d;
    logic [`ISB_SB_W-1:0] mask_q, mask_d;
    logic [`ISB_AGE_W-1:0] age_q, age_d;
    logic [`ISB_IDX_W-1:0] idx_q, idx_d;

    always_comb begin
        valid_d = valid_q;
        issued_d = issued_q;
        kind_d = kind_q;
        mask_d = mask_q;
        age_d = age_q;
        idx_d = idx_q;
        if (mark_issued) begin
            issued_d = 1'b1;
        end
        if (free) begin
            valid_d = 1'b0;
            issued_d = 1'b0;
        end
        if (alloc) begin
            valid_d = 1'b1;
            issued_d = 1'b0;
            kind_d = alloc_kind;
            mask_d = alloc_mask;
            age_d = alloc_age;
            idx_d = alloc_idx;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            valid_q <= 1'b0;
            issued_q <= 1'b0;
            kind_q <= isb_pkg::k_other;
            mask_q <= `ISB_SB_RST;
            age_q <= '0;
            idx_q <= '0;
        end else begin
            valid_q <= valid_d;
            issued_q <= issued_d;
            kind_q <= kind_d;
            mask_q <= mask_d;
            age_q <= age_d;
            idx_q <= idx_d;
        end
    end

    assign valid = valid_q;
    assign issued = issued_q;
    assign kind = kind_q;
    assign mask = mask_q;
    assign age = age_q;
    assign idx = idx_q;
endmodule

//--- src/isb_excreg.sv
`timescale 1ns/1ps
`include "isb_cfg.svh"

module isb_excreg #(
    parameter int W = 64
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic exc_valid,
    input wire logic [`ISB_AGE_W-1:0] exc_age,
    input wire logic [W-1:0] exc_data,
    input wire logic kill_valid,
    input wire logic [`ISB_AGE_W-1:0] kill_age,
    output logic [W-1:0] data,
    output logic locked
);
    isb_pkg::isb_lock_t st_q, st_d;
    logic [W-1:0] data_q, data_d;
    logic [`ISB_AGE_W-1:0] age_q, age_d;
    logic exc_live;

    always_comb begin
        st_d = st_q;
        data_d = data_q;
        age_d = age_q;
        // An exception from an instruction killed in the same cycle is void
        exc_live = exc_valid &&
            !(kill_valid && !isb_pkg::isb_older(exc_age, kill_age));
        case (st_q)
            isb_pkg::lk_default: begin
                if (exc_live) begin
                    data_d = exc_data;
                    age_d = exc_age;
                    st_d = isb_pkg::lk_locked;
                end
            end
            isb_pkg::lk_locked: begin
                if (kill_valid &&
                    !isb_pkg::isb_older(age_q, kill_age)) begin
                    st_d = isb_pkg::lk_default;
                    if (exc_live) begin
                        data_d = exc_data;
                        age_d = exc_age;
                        st_d = isb_pkg::lk_locked;
                    end
                end else if (exc_live &&
                    isb_pkg::isb_older(exc_age, age_q)) begin
                    data_d = exc_data;
                    age_d = exc_age;
                end
            end
            default: begin
                st_d = isb_pkg::lk_default;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= isb_pkg::lk_default;
            data_q <= '0;
            age_q <= '0;
        end else begin
            st_q <= st_d;
            data_q <= data_d;
            age_q <= age_d;
        end
    end

    assign data = data_q;
    assign locked = (st_q == isb_pkg::lk_locked);
endmodule

//--- testbench/isb_scoreboard_chk.sv
`timescale 1ns/1ps
`include "isb_cfg.svh"

module isb_scoreboard_chk (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic ent_accept_q,
    input wire logic [1:0] ent_kind,
    input wire logic [`ISB_SB_W-1:0] ent_mask,
    input wire logic iss_valid,
    input wire logic ret_valid,
    input wire logic kill_valid,
    input wire logic pte_load_issue,
    input wire logic exc_valid,
    input wire logic rd_valid_q,
    input wire logic tb_barrier_q,
    input wire logic exc_locked_q,
    input wire logic [`ISB_SB_W-1:0] sb_bits_q,
    input wire logic [`ISB_DW-1:0] data_tb_tag_reg_q,
    input wire logic [`ISB_DW-1:0] data_tb_entry_reg_q,
    input wire logic [`ISB_DW-1:0] exception_pc_reg_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_entry_clear;
        ent_accept_q && !ent_kind[1] |-> ($past(sb_bits_q) & ent_mask) == '0;
    endproperty
    a_entry_clear: assert property (p_entry_clear)
        else $error("entry taken over a set scoreboard bit");
    property p_entry_set;
        ent_accept_q && ent_kind == 2'h1 |-> (sb_bits_q & ent_mask) == ent_mask;
    endproperty
    a_entry_set: assert property (p_entry_set)
        else $error("write entered without setting its bits");
    property p_low_clear;
        |($past(sb_bits_q[3:0]) & ~sb_bits_q[3:0]) |->
            $past(iss_valid || kill_valid);
    endproperty
    a_low_clear: assert property (p_low_clear)
        else $error("low bit cleared without issue or abort");
    property p_up_clear;
        |($past(sb_bits_q[7:4]) & ~sb_bits_q[7:4]) |->
            $past(ret_valid || kill_valid);
    endproperty
    a_up_clear: assert property (p_up_clear)
        else $error("upper bit cleared without retire or abort");
    property p_barrier;
        pte_load_issue && sb_bits_q[0] |=> tb_barrier_q;
    endproperty
    a_barrier: assert property (p_barrier)
        else $error("barrier missing after table entry load");
    property p_barrier_cause;
        tb_barrier_q |-> $past(pte_load_issue && sb_bits_q[0]);
    endproperty
    a_barrier_cause: assert property (p_barrier_cause)
        else $error("barrier without cause");
    property p_commit;
        !ret_valid |=> $stable({data_tb_tag_reg_q, data_tb_entry_reg_q});
    endproperty
    a_commit: assert property (p_commit)
        else $error("committed register changed without retire");
    property p_implicit;
        $changed(exception_pc_reg_q) |-> $past(exc_valid);
    endproperty
    a_implicit: assert property (p_implicit)
        else $error("exception register written without exception");
    property p_lock;
        !exc_locked_q && exc_valid && !kill_valid ##1 !kill_valid |->
            ##[0:1] exc_locked_q;
    endproperty
    a_lock: assert property (p_lock)
        else $error("exception register did not lock");
    property p_read;
        rd_valid_q |-> $past(iss_valid);
    endproperty
    a_read: assert property (p_read)
        else $error("read data without issue");
endmodule

bind isb_scoreboard isb_scoreboard_chk u_chk (
    .ref_clk, .resetn, .ent_accept_q, .ent_kind, .ent_mask, .iss_valid,
    .ret_valid, .kill_valid, .pte_load_issue, .exc_valid, .rd_valid_q,
    .tb_barrier_q, .exc_locked_q, .sb_bits_q, .data_tb_tag_reg_q,
    .data_tb_entry_reg_q, .exception_pc_reg_q
);

//--- testbench/isb_map_model.sv
`timescale 1ns/1ps
`include "isb_cfg.svh"

module isb_map_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [`ISB_SB_W-1:0] mask,
    input wire logic [`ISB_IDX_W-1:0] idx,
    input wire logic [`ISB_AGE_W-1:0] age,
    input wire logic [3:0] delay,
    input wire logic ent_accept_q,
    input wire logic [`ISB_SLOT_W-1:0] ent_slot_q,
    output logic ent_valid,
    output logic [1:0] ent_kind,
    output logic [`ISB_SB_W-1:0] ent_mask,
    output logic [`ISB_IDX_W-1:0] ent_idx,
    output logic [`ISB_AGE_W-1:0] ent_age,
    output logic done,
    output logic [`ISB_SLOT_W-1:0] slot
);
    logic pend_q;
    logic [3:0] wait_q;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ent_valid <= 1'b0;
            {ent_kind, ent_mask, ent_idx, ent_age} <= '0;
            pend_q <= 1'b0;
            wait_q <= 4'h0;
            done <= 1'b1;
            slot <= 3'h0;
        end else if (go) begin
            // Caller's masks carry the software ordering
            {ent_kind, ent_mask, ent_idx, ent_age} <= {kind, mask, idx, age};
            wait_q <= delay;
            pend_q <= 1'b1;
            done <= 1'b0;
        end else if (ent_valid && ent_accept_q) begin
            // Drop at once, a held request would be taken twice
            ent_valid <= 1'b0;
            pend_q <= 1'b0;
            done <= 1'b1;
            slot <= ent_slot_q;
        end else if (pend_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end else if (pend_q) begin
            ent_valid <= 1'b1;
        end
    end
endmodule

//--- testbench/isb_scoreboard_tb.sv
`timescale 1ns/1ps
`include "isb_cfg.svh"

module isb_scoreboard_tb;
    typedef struct packed {
        logic [7:0] mask;
        logic [2:0] idx;
        logic [63:0] wdata;
        logic [7:0] sb_iss;
    } isb_row_t;

    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic go = 1'b0;
    logic [1:0] m_kind = 2'h0;
    logic [7:0] m_mask = 8'h00, m_age = 8'h00, age_n = 8'h01;
    logic [3:0] m_delay = 4'h0, dly = 4'h0;
    logic iss_valid = 1'b0, ret_valid = 1'b0, kill_valid = 1'b0;
    logic pte_load_issue = 1'b0, exc_valid = 1'b0, done;
    logic [2:0] iss_slot = 3'h0, ret_slot = 3'h0, m_idx = 3'h0;
    logic [63:0] iss_wdata = 64'h0, exc_pc = 64'h0, exc_va;
    logic [7:0] kill_age = 8'h00, exc_age = 8'h00;
    logic ent_valid, ent_accept_q, rd_valid_q, tb_barrier_q, exc_locked_q;
    logic [1:0] ent_kind;
    logic [7:0] ent_mask, ent_age, iss_ok_q, ret_ok_q, sb_bits_q;
    logic [2:0] ent_idx, ent_slot_q, slot;
    logic [63:0] rd_data_q, data_tb_tag_reg_q, data_tb_entry_reg_q;
    logic [63:0] exception_pc_reg_q, fault_virtual_address_reg_q;
    logic [15:0] exc_stat, memory_fault_status_reg_q;
    logic [63:0] exp_reg [2] = '{64'h0, 64'h0};
    int n_fail = 0, n_checks = 0;
    isb_row_t rows [4] = '{
        '{8'h01, 3'h0, 64'h0123_4567_89AB_CDEF, 8'h00},
        '{8'h10, 3'h1, 64'hFEDC_BA98_7654_3210, 8'h10},
        '{8'hC3, 3'h0, 64'h0F0F_0F0F_F0F0_F0F0, 8'hC0},
        '{8'hFF, 3'h1, 64'h8000_0000_0000_0001, 8'hF0}};

    assign exc_va = ~exc_pc;
    assign exc_stat = exc_pc[15:0];
    always #10 ref_clk = ~ref_clk;

    isb_scoreboard dut (.ref_clk, .resetn, .ent_valid, .ent_kind, .ent_mask,
        .ent_idx, .ent_age, .ent_accept_q, .ent_slot_q, .iss_valid, .iss_slot,
        .iss_wdata, .iss_ok_q, .rd_valid_q, .rd_data_q, .ret_valid, .ret_slot,
        .ret_ok_q, .kill_valid, .kill_age, .pte_load_issue, .tb_barrier_q,
        .sb_bits_q, .data_tb_tag_reg_q, .data_tb_entry_reg_q, .exc_valid,
        .exc_age, .exc_pc, .exc_va, .exc_stat, .exception_pc_reg_q,
        .fault_virtual_address_reg_q, .memory_fault_status_reg_q,
        .exc_locked_q);
    isb_map_model u_map (.ref_clk, .resetn, .go, .kind(m_kind),
        .mask(m_mask), .idx(m_idx), .age(m_age), .delay(m_delay),
        .ent_accept_q, .ent_slot_q, .ent_valid, .ent_kind, .ent_mask,
        .ent_idx, .ent_age, .done, .slot);

    task automatic chk(input string name, input logic [63:0] seen,
            input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic start(input logic [1:0] k, input logic [7:0] m,
            input logic [2:0] i);
        @(posedge ref_clk);
        {m_kind, m_mask, m_idx, m_age, m_delay} <= {k, m, i, age_n, dly};
        go <= 1'b1;
        age_n = age_n + 8'h01;
        @(posedge ref_clk);
        go <= 1'b0;
    endtask

    task automatic enter_wait(output logic [2:0] s);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (done !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        chk("entry taken", done, 1'b1);
        s = slot;
    endtask

    // Refused requests are dropped silently, so wait on the ready view
    task automatic step(input bit ret, input logic [2:0] s,
            input logic [63:0] d);
        int n;
        n = 0;
        while ((ret ? ret_ok_q[s] : iss_ok_q[s]) !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        chk("ready", n < 40, 1'b1);
        @(posedge ref_clk);
        {ret_slot, iss_slot, iss_wdata} <= {s, s, d};
        {ret_valid, iss_valid} <= {ret, !ret};
        @(posedge ref_clk);
        {ret_valid, iss_valid} <= 2'b00;
        @(negedge ref_clk);
    endtask

    task automatic ev(input bit kill, input logic [7:0] a,
            input logic [63:0] p);
        @(posedge ref_clk);
        {kill_age, exc_age, exc_pc} <= {a, a, p};
        {kill_valid, exc_valid} <= {kill, !kill};
        @(posedge ref_clk);
        {kill_valid, exc_valid} <= 2'b00;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic pte(input logic e);
        @(posedge ref_clk);
        pte_load_issue <= 1'b1;
        @(posedge ref_clk);
        pte_load_issue <= 1'b0;
        @(negedge ref_clk);
        chk("barrier", tb_barrier_q, e);
    endtask

    initial begin
        logic [2:0] s, s2;
        logic [7:0] a;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        chk("sb reset", sb_bits_q, 8'h00);
        chk("lock reset", exc_locked_q, 1'b0);
        foreach (rows[r]) begin
            start(2'h1, rows[r].mask, rows[r].idx);
            enter_wait(s);
            chk("sb entry", sb_bits_q, rows[r].mask);
            step(0, s, rows[r].wdata);
            chk("sb issue", sb_bits_q, rows[r].sb_iss);
            chk("tag held", data_tb_tag_reg_q, exp_reg[0]);
            chk("entry held", data_tb_entry_reg_q, exp_reg[1]);
            step(1, s, 64'h0);
            exp_reg[rows[r].idx[0]] = rows[r].wdata;
            chk("sb retire", sb_bits_q, 8'h00);
            chk("tag", data_tb_tag_reg_q, exp_reg[0]);
            chk("entry", data_tb_entry_reg_q, exp_reg[1]);
        end
        start(2'h1, 8'h80, 3'h1);
        enter_wait(s);
        step(0, s, 64'hA5A5_0000_5A5A_FFFF);
        start(2'h0, 8'h80, 3'h1);
        repeat (6) @(negedge ref_clk);
        chk("read held", done, 1'b0);
        step(1, s, 64'h0);
        enter_wait(s2);
        step(0, s2, 64'h0);
        chk("read valid", rd_valid_q, 1'b1);
        chk("read data", rd_data_q, 64'hA5A5_0000_5A5A_FFFF);
        step(1, s2, 64'h0);
        start(2'h1, 8'h01, 3'h0);
        enter_wait(s);
        dly = 4'h3;
        start(2'h2, 8'h00, 3'h0);
        enter_wait(s2);
        dly = 4'h0;
        repeat (2) @(negedge ref_clk);
        chk("load held", iss_ok_q[s2], 1'b0);
        pte(1'b1);
        step(0, s, 64'h1);
        chk("sb low", sb_bits_q, 8'h00);
        pte(1'b0);
        repeat (2) @(negedge ref_clk);
        chk("load free", iss_ok_q[s2], 1'b1);
        step(0, s2, 64'h0);
        step(1, s, 64'h0);
        step(1, s2, 64'h0);
        a = age_n;
        start(2'h1, 8'h22, 3'h0);
        enter_wait(s);
        chk("sb kill set", sb_bits_q, 8'h22);
        ev(1'b1, a, 64'h0);
        chk("sb abort", sb_bits_q, 8'h00);
        ev(1'b0, 8'h40, 64'h1111);
        chk("pc", exception_pc_reg_q, 64'h1111);
        chk("va", fault_virtual_address_reg_q, ~64'h1111);
        chk("stat", memory_fault_status_reg_q, 16'h1111);
        chk("locked", exc_locked_q, 1'b1);
        ev(1'b0, 8'h50, 64'h2222);
        chk("younger", exception_pc_reg_q, 64'h1111);
        ev(1'b0, 8'h30, 64'h3333);
        chk("older", exception_pc_reg_q, 64'h3333);
        ev(1'b1, 8'h30, 64'h0);
        chk("unlock", exc_locked_q, 1'b0);
        ev(1'b0, 8'h60, 64'h4444);
        chk("recapture", exception_pc_reg_q, 64'h4444);
        ev(1'b1, 8'h70, 64'h0);
        chk("kept lock", exc_locked_q, 1'b1);
        conclude();
    end

    // Tests need under a thousand cycles
    initial begin
        #400000;
        n_fail++;
        conclude();
    end
endmodule
